// file: verilog/svw_top.sv
// supply supervisor and watchdog reset block, top level
//
// Function
// R1 - select high deselects the device; serial output floats.
// R2 - select high means standby unless nonvolatile write runs; low means active.
// R3 - no operation accepted until a select falling edge after power-up.
// R4 - each select/kick falling edge restarts the watchdog count from zero.
// R5 - no falling edge within the timeout asserts reset.
// R6 - watchdog reset only when enabled and input stays still past timeout.
// R7 - host must toggle select/kick before each timeout expires.
// R8 - serial output updates on each serial clock falling edge during reads.
// R9 - opcode, address and data sampled on serial clock rising edges.
// R10 - host sends every byte most significant bit first.
// R11 - reset active low, held until supply good for 200 ms continuously.
// R12 - power-up reset asserts at 1 V, held 200 ms after supply settles.
// R13 - reset stays asserted during collapse until supply is below 1 V.
// R14 - program enable low freezes the undervoltage threshold setting.
// R15 - two nonvolatile bits in the watchdog register choose the period.
// R16 - period codes: 00 1.4 s, 01 600 ms, 10 200 ms, 11 off.
// R17 - periods and release delay counted in internal timebase ticks.
`timescale 1ns/1ps
module svw_top
   import svw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES  = TICK_DIV,
   parameter int unsigned RELEASE_TK   = RELEASE_TICKS,
   parameter int unsigned WD_LONG_TK   = WD_LONG_TICKS,
   parameter int unsigned WD_MID_TK    = WD_MID_TICKS,
   parameter int unsigned WD_SHORT_TK  = WD_SHORT_TICKS,
   parameter int unsigned NV_CYCLES    = NV_WRITE_CYC
)(
   input  wire logic       SYS_CLK_I,
   input  wire logic       RSTN_I,
   input  wire logic       SCK_I,
   input  wire logic       SELECT_KICK_N_I,
   input  wire logic       SI_I,
   input  wire logic       SUPPLY_OK_I,
   input  wire logic       SUPPLY_ABOVE_1V_I,
   input  wire logic       THRESHOLD_PROGRAM_ENABLE_I,
   input  wire logic [3:0] THRESHOLD_CODE_I,
   input  wire logic       THRESHOLD_LOAD_I,
   output logic            SO_O,
   output logic            SO_OE_O,
   output logic            RESET_N_O,
   output logic            RESET_OE_O,
   output logic            ACTIVE_O,
   output logic [3:0]      UNDERVOLTAGE_THRESHOLD_O
);
   // two flop synchronisers for every asynchronous input
   logic [1:0]  sel_sync_reg;
   logic [1:0]  sup_sync_reg;
   logic [1:0]  v1_sync_reg;
   logic [1:0]  vpe_sync_reg;
   logic [1:0]  ld_sync_reg;
   logic [1:0]  tgl_sync_reg;
   logic        sel_d_reg;
   logic        tgl_d_reg;
   logic        ld_d_reg;
   logic        armed_reg;
   logic        change_en_reg;
   logic [1:0]  psel_reg;
   logic        busy_reg;
   logic [31:0] nv_cnt_reg;
   logic [1:0]  psel_new_reg;
   logic [31:0] tick_cnt_reg;
   logic        tick_reg;
   logic [31:0] wd_cnt_reg;
   logic        wd_fire_reg;
   logic [31:0] rel_cnt_reg;
   logic        reset_hold_reg;
   logic [31:0] wd_limit;
   logic        sel_fall;
   logic        sel_rise;
   logic        set_pend_reg;
   logic [1:0]  so_sync_reg;
   logic [1:0]  oe_sync_reg;
   logic [3:0]  thr_a_reg;
   logic [3:0]  thr_b_reg;
   logic        cmd_evt;
   logic        link_tgl;
   logic [7:0]  link_op;
   logic [7:0]  link_data;
   logic        link_so;
   logic        link_oe;

   svw_link u_link (
      .sck_i      (SCK_I),
      .rst_n_i    (RSTN_I),
      .select_n_i (SELECT_KICK_N_I),
      .si_i       (SI_I),
      .psel_i     (psel_reg),
      .busy_i     (busy_reg),
      .cmd_tgl_o  (link_tgl),
      .cmd_op_o   (link_op),
      .cmd_data_o (link_data),
      .so_o       (link_so),
      .so_oe_o    (link_oe)
   );

   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sel_sync_reg <= 2'h3;
         sup_sync_reg <= 2'h0;
         v1_sync_reg  <= 2'h0;
         vpe_sync_reg <= 2'h0;
         ld_sync_reg  <= 2'h0;
         tgl_sync_reg <= 2'h0;
         sel_d_reg    <= 1'b1;
         tgl_d_reg    <= 1'b0;
         ld_d_reg     <= 1'b0;
         so_sync_reg  <= 2'h0;
         oe_sync_reg  <= 2'h0;
         thr_a_reg    <= 4'h0;
         thr_b_reg    <= 4'h0;
      end else begin
         so_sync_reg  <= {so_sync_reg[0], link_so};
         oe_sync_reg  <= {oe_sync_reg[0], link_oe};
         thr_a_reg    <= THRESHOLD_CODE_I;
         thr_b_reg    <= thr_a_reg;
         sel_sync_reg <= {sel_sync_reg[0], SELECT_KICK_N_I};
         sup_sync_reg <= {sup_sync_reg[0], SUPPLY_OK_I};
         v1_sync_reg  <= {v1_sync_reg[0], SUPPLY_ABOVE_1V_I};
         vpe_sync_reg <= {vpe_sync_reg[0], THRESHOLD_PROGRAM_ENABLE_I};
         ld_sync_reg  <= {ld_sync_reg[0], THRESHOLD_LOAD_I};
         tgl_sync_reg <= {tgl_sync_reg[0], link_tgl};
         sel_d_reg    <= sel_sync_reg[1];
         tgl_d_reg    <= tgl_sync_reg[1];
         ld_d_reg     <= ld_sync_reg[1];
      end
   end

   assign sel_fall = sel_d_reg & ~sel_sync_reg[1];
   assign sel_rise = ~sel_d_reg & sel_sync_reg[1];
   assign cmd_evt  = (tgl_d_reg != tgl_sync_reg[1]);

   // an accepted set command waits for select to rise before the write starts
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I)
         set_pend_reg <= 1'b0;
      else if (sel_rise || sel_fall)
         set_pend_reg <= 1'b0;
      else if (cmd_evt && armed_reg && change_en_reg && !busy_reg)
         set_pend_reg <= (link_op == OP_SET_PERIOD);
   end

   // link commands are dropped until the first select falling edge
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I)
         armed_reg <= 1'b0;
      else if (sel_fall)
         armed_reg <= 1'b1; // R3
   end

   // watchdog change latch and new period bits waiting for the write cycle
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         change_en_reg <= 1'b0;
         psel_new_reg  <= PSEL_RESET;
      end else if (busy_reg && nv_cnt_reg == 32'(NV_CYCLES - 1)) begin
         change_en_reg <= 1'b0;
      end else if (cmd_evt && armed_reg && !busy_reg) begin
         case (link_op)
            OP_EN_CHANGE:  change_en_reg <= 1'b1;
            OP_DIS_CHANGE: change_en_reg <= 1'b0;
            OP_SET_PERIOD: psel_new_reg  <= link_data[PSEL_HI_POS -: 2];
            default:       change_en_reg <= change_en_reg;
         endcase
      end
   end

   // write cycle: started by a set command; its end commits the new period
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         busy_reg   <= 1'b0;
         nv_cnt_reg <= 32'h0;
         psel_reg   <= PSEL_RESET;
      end else if (busy_reg) begin
         nv_cnt_reg <= nv_cnt_reg + 32'h1;
         if (nv_cnt_reg == 32'(NV_CYCLES - 1)) begin
            busy_reg <= 1'b0;
            psel_reg <= psel_new_reg; // R15
         end
      end else if (sel_rise && set_pend_reg) begin
         busy_reg   <= 1'b1;
         nv_cnt_reg <= 32'h0;
      end
   end

   // active while selected or while a write cycle runs
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I)
         ACTIVE_O <= 1'b0;
      else
         ACTIVE_O <= ~sel_sync_reg[1] | busy_reg; // R2
   end

   // threshold setting frozen unless program enable is high
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I)
         UNDERVOLTAGE_THRESHOLD_O <= 4'h0;
      else if (vpe_sync_reg[1] && ld_sync_reg[1] && !ld_d_reg)
         UNDERVOLTAGE_THRESHOLD_O <= thr_b_reg; // R14
   end

   // internal timebase
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tick_cnt_reg <= 32'h0;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 32'h0;
         tick_reg     <= 1'b1; // R17
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
         tick_reg     <= 1'b0;
      end
   end

   always_comb begin
      case (psel_reg)
         PSEL_LONG:  wd_limit = 32'(WD_LONG_TK); // R16
         PSEL_MID:   wd_limit = 32'(WD_MID_TK);
         PSEL_SHORT: wd_limit = 32'(WD_SHORT_TK);
         default:    wd_limit = 32'h0;
      endcase
   end

   // watchdog: kick clears, overflow fires a one-cycle request
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         wd_cnt_reg  <= 32'h0;
         wd_fire_reg <= 1'b0;
      end else if (sel_fall || psel_reg == PSEL_OFF || reset_hold_reg) begin
         wd_cnt_reg  <= 32'h0; // R4 R6
         wd_fire_reg <= 1'b0;
      end else if (tick_reg) begin
         if (wd_cnt_reg >= wd_limit) begin
            wd_cnt_reg  <= 32'h0;
            wd_fire_reg <= 1'b1; // R5
         end else begin
            wd_cnt_reg  <= wd_cnt_reg + 32'h1;
            wd_fire_reg <= 1'b0;
         end
      end else begin
         wd_fire_reg <= 1'b0;
      end
   end

   // reset held until supply good for the whole release delay
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rel_cnt_reg    <= 32'h0;
         reset_hold_reg <= 1'b1;
      end else if (!sup_sync_reg[1] || wd_fire_reg) begin
         rel_cnt_reg    <= 32'h0; // R11 R12
         reset_hold_reg <= 1'b1;
      end else if (reset_hold_reg && tick_reg) begin
         if (rel_cnt_reg == 32'(RELEASE_TK - 1))
            reset_hold_reg <= 1'b0;
         else
            rel_cnt_reg <= rel_cnt_reg + 32'h1;
      end
   end

   // open drain: below 1 V the pin cannot be driven, so it is released
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         RESET_N_O  <= 1'b0;
         RESET_OE_O <= 1'b0;
      end else begin
         RESET_N_O  <= 1'b0;
         RESET_OE_O <= reset_hold_reg & v1_sync_reg[1]; // R13
      end
   end

   // serial output retimed onto the system clock
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         SO_O    <= 1'b0;
         SO_OE_O <= 1'b0;
      end else begin
         SO_O    <= so_sync_reg[1];
         SO_OE_O <= oe_sync_reg[1] & ~sel_sync_reg[1]; // R1
      end
   end
endmodule

// file: verilog/svw_pkg.sv
// constants and types for the supervisor and watchdog reset block
package svw_pkg;
   localparam int unsigned SYS_CLK_HZ      = 200_000_000;
   // timebase tick derived from the system clock
   localparam int unsigned TICK_HZ         = 1_000;
   localparam int unsigned TICK_DIV        = SYS_CLK_HZ / TICK_HZ;
   localparam int unsigned RELEASE_MS      = 200;
   localparam int unsigned WD_LONG_MS      = 1400;
   localparam int unsigned WD_MID_MS       = 600;
   localparam int unsigned WD_SHORT_MS     = 200;
   localparam int unsigned RELEASE_TICKS   = RELEASE_MS * TICK_HZ / 1000;
   localparam int unsigned WD_LONG_TICKS   = WD_LONG_MS * TICK_HZ / 1000;
   localparam int unsigned WD_MID_TICKS    = WD_MID_MS * TICK_HZ / 1000;
   localparam int unsigned WD_SHORT_TICKS  = WD_SHORT_MS * TICK_HZ / 1000;
   localparam int unsigned TICK_W          = 16;
   // opcodes
   localparam logic [7:0]  OP_EN_CHANGE    = 8'h06;
   localparam logic [7:0]  OP_DIS_CHANGE   = 8'h04;
   localparam logic [7:0]  OP_SET_PERIOD   = 8'h01;
   localparam logic [7:0]  OP_READ_PERIOD  = 8'h05;
   // watchdog register layout
   localparam int unsigned PSEL_LO_POS     = 3;
   localparam int unsigned PSEL_HI_POS     = 4;
   localparam logic [1:0]  PSEL_RESET      = 2'h0;
   localparam logic [1:0]  PSEL_LONG       = 2'h0;
   localparam logic [1:0]  PSEL_MID        = 2'h1;
   localparam logic [1:0]  PSEL_SHORT      = 2'h2;
   localparam logic [1:0]  PSEL_OFF        = 2'h3;
   localparam int unsigned NV_WRITE_CYC    = 1000;
   typedef enum logic [1:0] {
      SVW_OPCODE = 2'b00,
      SVW_DATA   = 2'b01,
      SVW_SHIFT  = 2'b11,
      SVW_IGNORE = 2'b10
   } svw_link_st_t;
endpackage

// file: verilog/svw_link.sv
// serial link end, clocked by the host serial clock
`timescale 1ns/1ps
module svw_link
   import svw_pkg::*;
(
   input  wire logic       sck_i,
   input  wire logic       rst_n_i,
   input  wire logic       select_n_i,
   input  wire logic       si_i,
   input  wire logic [1:0] psel_i,
   input  wire logic       busy_i,
   output logic            cmd_tgl_o,
   output logic [7:0]      cmd_op_o,
   output logic [7:0]      cmd_data_o,
   output logic            so_o,
   output logic            so_oe_o
);
   svw_link_st_t state_reg;
   logic [2:0]   bit_reg;
   logic [7:0]   sh_reg;
   logic [7:0]   out_reg;
   logic [7:0]   rx_next;

   assign rx_next = {sh_reg[6:0], si_i};

   // select high acts as the link reset; the clock may stop between frames
   always_ff @(posedge sck_i or posedge select_n_i) begin
      if (select_n_i) begin
         state_reg <= SVW_OPCODE;
         bit_reg   <= 3'h0;
         sh_reg    <= 8'h00;
      end else begin
         sh_reg  <= rx_next; // R9 R10
         bit_reg <= bit_reg + 3'h1;
         if (bit_reg == 3'h7) begin
            case (state_reg)
               SVW_OPCODE: begin
                  if (rx_next == OP_SET_PERIOD)
                     state_reg <= SVW_DATA;
                  else if (rx_next == OP_READ_PERIOD)
                     state_reg <= SVW_SHIFT;
                  else
                     state_reg <= SVW_IGNORE;
               end
               default: state_reg <= SVW_IGNORE;
            endcase
         end
      end
   end

   // command words handed over with a toggle; held stable while it flips.
   // not cleared by select: a reset toggle would look like a fresh command
   always_ff @(posedge sck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_tgl_o  <= 1'b0;
         cmd_op_o   <= 8'h00;
         cmd_data_o <= 8'h00;
      end else if (bit_reg == 3'h7) begin
         if (state_reg == SVW_OPCODE && rx_next != OP_SET_PERIOD) begin
            cmd_op_o  <= rx_next;
            cmd_tgl_o <= ~cmd_tgl_o;
         end else if (state_reg == SVW_DATA) begin
            cmd_op_o   <= OP_SET_PERIOD;
            cmd_data_o <= rx_next;
            cmd_tgl_o  <= ~cmd_tgl_o;
         end
      end
   end

   // output shifts on the falling edge while a read is active
   always_ff @(negedge sck_i or posedge select_n_i) begin
      if (select_n_i) begin
         out_reg <= 8'h00;
         so_o    <= 1'b0;
         so_oe_o <= 1'b0; // R1
      end else if (state_reg == SVW_SHIFT) begin
         so_oe_o <= 1'b1;
         if (bit_reg == 3'h0) begin
            out_reg <= busy_i ? 8'hFF : 8'h00 | ({6'h00, psel_i} << PSEL_LO_POS);
            so_o    <= busy_i ? 1'b1 : 1'b0;
         end else begin
            so_o    <= out_reg[3'h7 - bit_reg]; // R8
         end
      end
   end
endmodule

// file: verification/svw_host.sv
// host serial master model: select/kick, serial clock and serial data
`timescale 1ns/1ps
module svw_host (
   output logic      sck_o,
   output logic      sel_n_o,
   output logic      si_o,
   input  wire logic so_i
);
   initial begin
      sck_o   = 1'b0;
      sel_n_o = 1'b1;
      si_o    = 1'b0;
   end
   // clock runs only inside frames; long low phase leaves room for the retimed output
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int low);
      for (int i = 7; i >= 0; i--) begin
         si_o = tx[i];
         #3 sck_o = 1'b1;
         rx[i] = so_i;
         #3 sck_o = 1'b0;
         #(low);
      end
   endtask
   task automatic kick();
      sel_n_o = 1'b0;
      #20 sel_n_o = 1'b1;
      si_o = ~si_o;
      #20;
   endtask
   task automatic frame(input logic [7:0] op, dat, input bit two, output logic [7:0] rx);
      sel_n_o = 1'b0;
      #10 xfer(op, rx, 0);
      if (two) begin
         #20 xfer(dat, rx, 17);
      end
      #10 sel_n_o = 1'b1;
      si_o = ~si_o;
      #30;
   endtask
endmodule

// file: verification/svw_top_checker.sv
// assertions on the supervisor and watchdog reset block ports
`timescale 1ns/1ps
module svw_top_checker
   import svw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 10,
   parameter int unsigned RELEASE_TK  = 5,
   parameter int unsigned WD_SHORT_TK = 6
)(
   input wire logic       SYS_CLK_I,
   input wire logic       RSTN_I,
   input wire logic       SELECT_KICK_N_I,
   input wire logic       SUPPLY_OK_I,
   input wire logic       SUPPLY_ABOVE_1V_I,
   input wire logic       THRESHOLD_PROGRAM_ENABLE_I,
   input wire logic       SO_OE_O,
   input wire logic       RESET_OE_O,
   input wire logic       ACTIVE_O,
   input wire logic [3:0] UNDERVOLTAGE_THRESHOLD_O
);
   logic        sel_q_reg;
   int unsigned kick_cnt_reg;
   int unsigned good_cnt_reg;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // raw edge counts earlier than the synced one, so the bound stays safe
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sel_q_reg    <= 1'b1;
         kick_cnt_reg <= '0;
      end else begin
         sel_q_reg    <= SELECT_KICK_N_I;
         kick_cnt_reg <= (sel_q_reg && !SELECT_KICK_N_I) ? '0 : kick_cnt_reg + 1;
      end
   end
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         good_cnt_reg <= '0;
      end else begin
         good_cnt_reg <= SUPPLY_OK_I ? good_cnt_reg + 1 : '0;
      end
   end
   property p_float; SELECT_KICK_N_I [*5] |-> !SO_OE_O; endproperty
   a_float: assert property (p_float) else $error("output driven while deselected");
   property p_active; !SELECT_KICK_N_I [*5] |-> ACTIVE_O; endproperty
   a_active: assert property (p_active) else $error("not active while selected");
   property p_pwrup; $rose(RSTN_I) && SUPPLY_ABOVE_1V_I |-> ##[0:3] RESET_OE_O; endproperty
   a_pwrup: assert property (p_pwrup) else $error("no reset at power-up");
   property p_uv; $fell(SUPPLY_OK_I) && SUPPLY_ABOVE_1V_I |-> ##[1:6] RESET_OE_O; endproperty
   a_uv: assert property (p_uv) else $error("undervoltage without reset");
   property p_hold; (!SUPPLY_OK_I && SUPPLY_ABOVE_1V_I) [*6] |-> RESET_OE_O; endproperty
   a_hold: assert property (p_hold) else $error("reset dropped during collapse");
   property p_rel; $fell(RESET_OE_O) |-> good_cnt_reg >= (RELEASE_TK - 1) * TICK_CYCLES;
   endproperty
   a_rel: assert property (p_rel) else $error("reset released early");
   property p_wd;
      $rose(RESET_OE_O) && $past(RSTN_I) && $past(RSTN_I, 2) && $past(RSTN_I, 3)
         && $past(RSTN_I, 8)
         && SUPPLY_OK_I && $past(SUPPLY_OK_I, 8)
         |-> kick_cnt_reg >= (WD_SHORT_TK - 1) * TICK_CYCLES;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog reset before timeout");
   property p_thr;
      !THRESHOLD_PROGRAM_ENABLE_I [*4] |-> $stable(UNDERVOLTAGE_THRESHOLD_O);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold changed while locked");
endmodule
bind svw_top svw_top_checker #(
   .TICK_CYCLES(TICK_CYCLES),
   .RELEASE_TK (RELEASE_TK),
   .WD_SHORT_TK(WD_SHORT_TK)
) u_chk (
   .SYS_CLK_I                 (SYS_CLK_I),
   .RSTN_I                    (RSTN_I),
   .SELECT_KICK_N_I           (SELECT_KICK_N_I),
   .SUPPLY_OK_I               (SUPPLY_OK_I),
   .SUPPLY_ABOVE_1V_I         (SUPPLY_ABOVE_1V_I),
   .THRESHOLD_PROGRAM_ENABLE_I(THRESHOLD_PROGRAM_ENABLE_I),
   .SO_OE_O                   (SO_OE_O),
   .RESET_OE_O                (RESET_OE_O),
   .ACTIVE_O                  (ACTIVE_O),
   .UNDERVOLTAGE_THRESHOLD_O  (UNDERVOLTAGE_THRESHOLD_O)
);

// file: verification/svw_top_tb.sv
// testbench for the supervisor and watchdog reset block
`timescale 1ns/1ps
module svw_top_tb;
   import svw_pkg::*;
   localparam int TK = 10;
   localparam int WL = 12;
   localparam int WM = 9;
   localparam int WS = 6;
   logic       clk    = 1'b0;
   logic       rstn   = 1'b0;
   logic       sup_ok = 1'b1;
   logic       pe     = 1'b0;
   logic       ld     = 1'b0;
   logic [3:0] thr    = 4'h0;
   logic [3:0] uvt;
   logic [7:0] rx;
   wire        sck, sel_n, si, so, so_oe, rst_oe, act;
   wire        so_w = so_oe ? so : 1'bz;
   int         fail_count = 0;
   int         cmp_count  = 0;
   always #2.5 clk = ~clk;
   svw_top #(.TICK_CYCLES(TK), .RELEASE_TK(5), .WD_LONG_TK(WL), .WD_MID_TK(WM),
      .WD_SHORT_TK(WS), .NV_CYCLES(20)) dut (
      .SYS_CLK_I(clk), .RSTN_I(rstn), .SCK_I(sck), .SELECT_KICK_N_I(sel_n), .SI_I(si),
      .SUPPLY_OK_I(sup_ok), .SUPPLY_ABOVE_1V_I(1'b1), .THRESHOLD_PROGRAM_ENABLE_I(pe),
      .THRESHOLD_CODE_I(thr), .THRESHOLD_LOAD_I(ld), .SO_O(so), .SO_OE_O(so_oe),
      .RESET_N_O(), .RESET_OE_O(rst_oe), .ACTIVE_O(act), .UNDERVOLTAGE_THRESHOLD_O(uvt));
   svw_host host (.sck_o(sck), .sel_n_o(sel_n), .si_o(si), .so_i(so_w));
   task automatic chk(input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic close_out();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // cycles until the reset enable reaches v must fall inside lo..hi
   task automatic wait_rst(input logic v, input int lo, hi);
      int n;
      n = 0;
      while (rst_oe !== v && n <= hi) begin
         @(negedge clk);
         n++;
      end
      chk(8'h1, {7'h0, (n >= lo && n <= hi)});
   endtask
   task automatic idle(input int n);
      repeat (n / 20) begin
         host.kick();
         repeat (12) @(negedge clk);
      end
   endtask
   task automatic rd_chk(input logic [7:0] e);
      host.frame(OP_READ_PERIOD, 8'h00, 1'b1, rx);
      chk(e, rx);
      repeat (3) @(negedge clk);
      chk(8'h0, {7'h0, so_oe});
   endtask
   task automatic wr(input logic [1:0] c, input bit en);
      if (en) begin
         host.frame(OP_EN_CHANGE, 8'h00, 1'b0, rx);
      end
      host.frame(OP_SET_PERIOD, {3'h0, c, 3'h0}, 1'b1, rx);
      idle(60);
   endtask
   task automatic t_powerup();
      wait_rst(1'b1, 0, 4);
      chk(8'h0, {7'h0, so_oe});
      wait_rst(1'b0, 37, 65);
      idle(20);
   endtask
   task automatic t_dip();
      @(posedge clk) sup_ok <= 1'b0;
      wait_rst(1'b1, 0, 6);
      idle(100);
      chk(8'h1, {7'h0, rst_oe});
      @(posedge clk) sup_ok <= 1'b1;
      wait_rst(1'b0, 37, 65);
      idle(20);
   endtask
   task automatic t_thr();
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         pe  <= p[0];
         thr <= 4'h5;
         repeat (4) @(posedge clk);
         ld <= 1'b1;
         repeat (4) @(posedge clk);
         ld <= 1'b0;
         repeat (4) @(negedge clk);
         chk(p[0] ? 8'h05 : 8'h00, {4'h0, uvt});
      end
   endtask
   task automatic t_periods();
      logic [1:0] c [3] = '{PSEL_MID, PSEL_SHORT, PSEL_LONG};
      int         lim [3] = '{WM, WS, WL};
      rd_chk(8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(c[i], 1'b1);
         rd_chk({3'h0, c[i], 3'h0});
         host.kick();
         wait_rst(1'b1, (lim[i] - 1) * TK - 8, (lim[i] + 2) * TK + 5);
         wait_rst(1'b0, 35, 65);
         idle(20);
      end
      wr(PSEL_OFF, 1'b1);
      repeat (200) begin
         @(negedge clk);
         chk(8'h0, {7'h0, rst_oe});
      end
      // latch cleared by the last write, then set and cleared again
      wr(PSEL_LONG, 1'b0);
      rd_chk({3'h0, PSEL_OFF, 3'h0});
      host.frame(OP_EN_CHANGE, 8'h00, 1'b0, rx);
      host.frame(OP_DIS_CHANGE, 8'h00, 1'b0, rx);
      wr(PSEL_LONG, 1'b0);
      rd_chk({3'h0, PSEL_OFF, 3'h0});
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_powerup();
      t_dip();
      t_thr();
      t_periods();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      close_out();
   end
endmodule
